// >>> hw/sop_pkg.sv
package sop_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] LEFT_OFS = 4'h4;
    localparam logic [3:0] RIGHT_OFS = 4'h8;
    localparam logic [3:0] STATUS_OFS = 4'hc;

    // control fields
    localparam int CTRL_SLAVE_BIT = 0;
    localparam int CTRL_JUSTIFY_BIT = 1;
    localparam int CTRL_MSB_DELAY_SELECT_N_N_BIT = 2;
    localparam int CTRL_POLARITY_BIT = 3;
    localparam int CTRL_ENABLE_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h04;

    // status fields
    localparam int STAT_IDX_LSB = 0;
    localparam int STAT_CHAN_BIT = 5;
    localparam int STAT_FRAME_BIT = 6;
    localparam int STAT_BUSY_BIT = 7;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ---------------------------------------------------------------
    // word and field geometry
    // ---------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam logic [4:0] FIELD_LAST = 5'h1f;
    localparam logic [4:0] POS_LEFT = 5'h00;
    localparam logic [4:0] POS_I2S = 5'h01;
    localparam logic [4:0] POS_RIGHT = 5'h10;
    localparam logic [4:0] POS_RIGHT_DLY = 5'h11;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int MCLK_PERIOD_NS = 10;
    localparam int BCLK_HALF_NS = 40;
    localparam int BCLK_HALF_CYC = (BCLK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    typedef struct packed {
        logic enable;
        logic polarity;
        logic msb_delay_select_n;
        logic justify_select;
        logic slave;
    } mode_t;

endpackage

// >>> hw/adc_serial_output_port.sv
`timescale 1ns/1ps
module adc_serial_output_port import sop_pkg::*; #(
    parameter int DIV_HALF = BCLK_HALF_CYC
) (
    // clock and resets
    input wire logic mclk,
    input wire logic srst,
    input wire logic reset_n,
    // axi4-lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial link pins
    input wire logic bclk_in,
    output logic bclk_out,
    output logic bclk_oe,
    input wire logic channel_select_clock_in,
    output logic channel_select_clock_out,
    output logic channel_select_clock_oe,
    input wire logic word_frame_in,
    output logic word_frame_out,
    output logic word_frame_oe,
    output logic serial_data_out
);

    generate
        // the divider counter is 16 bits wide
        if (DIV_HALF < 1 || DIV_HALF > 65536) begin : g_bad_div
            $error("DIV_HALF must be 1 to 65536");
        end
    endgenerate

    // ---------------------------------------------------------------
    // reset: async assert, sync release
    // ---------------------------------------------------------------
    logic [1:0] arst_sync_r;
    logic rst;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            arst_sync_r <= 2'h0;
        end else begin
            arst_sync_r <= {arst_sync_r[0], 1'b1};
        end
    end
    assign rst = srst | ~arst_sync_r[1];

    // ---------------------------------------------------------------
    // register file and axi4-lite slave
    // ---------------------------------------------------------------
    mode_t mode_r, mode_nxt;
    logic [15:0] left_r, left_nxt, right_r, right_nxt;
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt;
    logic [3:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [7:0] status;

    assign s_axi_awready = ~aw_got_r & ~bvalid_r;
    assign s_axi_wready = ~w_got_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_comb begin
        logic have_aw, have_w;
        logic [3:0] wa;
        logic [31:0] wd;
        have_aw = aw_got_r | (s_axi_awvalid & s_axi_awready);
        have_w = w_got_r | (s_axi_wvalid & s_axi_wready);
        wa = aw_got_r ? awaddr_r : s_axi_awaddr;
        wd = w_got_r ? wdata_r : s_axi_wdata;
        mode_nxt = mode_r;
        left_nxt = left_r;
        right_nxt = right_r;
        aw_got_nxt = have_aw;
        w_got_nxt = have_w;
        awaddr_nxt = wa;
        wdata_nxt = wd;
        bvalid_nxt = bvalid_r & ~s_axi_bready;
        bresp_nxt = bresp_r;
        if (have_aw && have_w && !bvalid_r) begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            case (wa)
                CTRL_OFS: begin
                    if (s_axi_wstrb[0] || w_got_r) begin
                        mode_nxt = mode_t'(wd[4:0]);
                    end
                end
                LEFT_OFS: left_nxt = wd[15:0];
                RIGHT_OFS: right_nxt = wd[15:0];
                STATUS_OFS: bresp_nxt = RESP_OKAY;
                default: bresp_nxt = RESP_SLVERR;
            endcase
        end
        rvalid_nxt = rvalid_r & ~s_axi_rready;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            case (s_axi_araddr)
                CTRL_OFS: rdata_nxt = {27'h0, mode_r};
                LEFT_OFS: rdata_nxt = {16'h0, left_r};
                RIGHT_OFS: rdata_nxt = {16'h0, right_r};
                STATUS_OFS: rdata_nxt = {24'h0, status};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_r <= mode_t'(CTRL_RESET);
            left_r <= 16'h0000;
            right_r <= 16'h0000;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 4'h0;
            wdata_r <= 32'h0000_0000;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else begin
            mode_r <= mode_nxt;
            left_r <= left_nxt;
            right_r <= right_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ---------------------------------------------------------------
    // pin synchronisers and edge detection
    // ---------------------------------------------------------------
    logic [2:0] bclk_s_r, cs_s_r;
    logic [1:0] wf_s_r;
    logic ext_launch, ext_sample, cs_change;
    logic wf_input_mode;

    always_ff @(posedge mclk) begin
        if (rst) begin
            bclk_s_r <= 3'h0;
            cs_s_r <= 3'h0;
            wf_s_r <= 2'h0;
        end else begin
            bclk_s_r <= {bclk_s_r[1:0], bclk_in};
            cs_s_r <= {cs_s_r[1:0], channel_select_clock_in};
            wf_s_r <= {wf_s_r[0], word_frame_in};
        end
    end

    // polarity high: launch on the falling edge
    assign ext_launch = (bclk_s_r[2] != bclk_s_r[1]) && (bclk_s_r[1] == ~mode_r.polarity);
    assign ext_sample = (bclk_s_r[2] != bclk_s_r[1]) && (bclk_s_r[1] == mode_r.polarity);
    assign cs_change = cs_s_r[2] != cs_s_r[1];
    assign wf_input_mode = mode_r.slave & mode_r.justify_select & ~mode_r.msb_delay_select_n;

    // ---------------------------------------------------------------
    // master bit clock divider
    // ---------------------------------------------------------------
    logic [15:0] div_r, div_nxt;
    logic bclk_r, bclk_nxt, tog_r, tog_nxt, m_launch;

    always_comb begin
        div_nxt = div_r;
        bclk_nxt = bclk_r;
        tog_nxt = 1'b0;
        if (!mode_r.enable || mode_r.slave) begin
            div_nxt = 16'h0000;
            bclk_nxt = mode_r.polarity;
        end else if (div_r == 16'(DIV_HALF - 1)) begin
            div_nxt = 16'h0000;
            bclk_nxt = ~bclk_r;
            tog_nxt = 1'b1;
        end else begin
            div_nxt = div_r + 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            div_r <= 16'h0000;
            bclk_r <= 1'b0;
            tog_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            bclk_r <= bclk_nxt;
            tog_r <= tog_nxt;
        end
    end

    // outputs move one master clock after the launch edge has left the pin
    assign m_launch = tog_r && (bclk_r == ~mode_r.polarity);

    // ---------------------------------------------------------------
    // field position and serialiser
    // ---------------------------------------------------------------
    logic [4:0] idx_r, idx_nxt, rem_r, rem_nxt, msb_pos;
    logic chan_r, chan_nxt, pend_r, pend_nxt, armed_r, armed_nxt;
    logic started_r, started_nxt, wf_r, wf_nxt, dout_r, dout_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic launch;

    assign launch = mode_r.enable & (mode_r.slave ? ext_launch : m_launch);
    assign msb_pos = mode_r.justify_select ?
        (mode_r.msb_delay_select_n ? POS_RIGHT : POS_RIGHT_DLY) :
        (mode_r.msb_delay_select_n ? POS_LEFT : POS_I2S);

    always_comb begin
        logic start;
        logic [15:0] word;
        start = 1'b0;
        word = 16'h0000;
        idx_nxt = idx_r;
        chan_nxt = chan_r;
        pend_nxt = pend_r;
        armed_nxt = armed_r;
        started_nxt = started_r;
        rem_nxt = rem_r;
        shift_nxt = shift_r;
        wf_nxt = wf_r;
        dout_nxt = dout_r;
        if (mode_r.slave && cs_change) begin
            pend_nxt = 1'b1;
        end
        if (ext_sample && wf_input_mode && !started_r && wf_s_r[1]) begin
            armed_nxt = 1'b1;
        end
        if (launch) begin
            if (mode_r.slave) begin
                if (pend_r || cs_change) begin
                    idx_nxt = 5'h00;
                    chan_nxt = cs_s_r[1];
                    pend_nxt = 1'b0;
                end else if (idx_r != FIELD_LAST) begin
                    idx_nxt = idx_r + 5'h01;
                end
            end else begin
                idx_nxt = idx_r + 5'h01;
                if (idx_r == FIELD_LAST) begin
                    chan_nxt = ~chan_r;
                end
            end
            if (idx_nxt == 5'h00) begin
                started_nxt = 1'b0;
            end
            if (wf_input_mode) begin
                start = armed_r && !started_r && idx_nxt != 5'h00;
                armed_nxt = 1'b0;
            end else begin
                start = idx_nxt == msb_pos;
            end
            // field high carries the left word, so left always leads in master mode
            word = chan_nxt ? left_r : right_r;
            if (start) begin
                started_nxt = 1'b1;
                dout_nxt = word[WORD_BITS-1];
                shift_nxt = {word[14:0], 1'b0};
                rem_nxt = 5'(WORD_BITS - 1);
            end else if (rem_r != 5'h00) begin
                dout_nxt = shift_r[15];
                shift_nxt = {shift_r[14:0], 1'b0};
                rem_nxt = rem_r - 5'h01;
            end else begin
                dout_nxt = 1'b0;
            end
            if (mode_r.justify_select) begin
                wf_nxt = mode_r.msb_delay_select_n ? (idx_nxt >= POS_RIGHT) :
                    (idx_nxt == POS_RIGHT);
            end else begin
                wf_nxt = mode_r.msb_delay_select_n ? (idx_nxt < POS_RIGHT) :
                    (idx_nxt >= POS_I2S && idx_nxt <= POS_RIGHT);
            end
        end
        if (!mode_r.enable) begin
            idx_nxt = FIELD_LAST;
            chan_nxt = 1'b0;
            pend_nxt = 1'b0;
            armed_nxt = 1'b0;
            started_nxt = 1'b0;
            rem_nxt = 5'h00;
            wf_nxt = 1'b0;
            dout_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            idx_r <= FIELD_LAST;
            chan_r <= 1'b0;
            pend_r <= 1'b0;
            armed_r <= 1'b0;
            started_r <= 1'b0;
            rem_r <= 5'h00;
            shift_r <= 16'h0000;
            wf_r <= 1'b0;
            dout_r <= 1'b0;
        end else begin
            idx_r <= idx_nxt;
            chan_r <= chan_nxt;
            pend_r <= pend_nxt;
            armed_r <= armed_nxt;
            started_r <= started_nxt;
            rem_r <= rem_nxt;
            shift_r <= shift_nxt;
            wf_r <= wf_nxt;
            dout_r <= dout_nxt;
        end
    end

    // ---------------------------------------------------------------
    // pins and status
    // ---------------------------------------------------------------
    // the reset pin silences the link at once; registers only follow on the next clock
    assign bclk_out = bclk_r & arst_sync_r[1];
    assign bclk_oe = ~mode_r.slave;
    assign channel_select_clock_out = chan_r & arst_sync_r[1];
    assign channel_select_clock_oe = ~mode_r.slave;
    assign word_frame_out = wf_r & arst_sync_r[1];
    assign word_frame_oe = ~wf_input_mode;
    assign serial_data_out = dout_r & arst_sync_r[1];
    assign status = {rem_r != 5'h00, wf_r, chan_r, idx_r};

endmodule

// >>> verification/sop_checker.sv
`timescale 1ns/1ps
module sop_checker #(
    parameter int DIV_HALF = 4
) (
    // clock and resets
    input wire logic mclk,
    input wire logic srst,
    input wire logic reset_n,
    // link pins
    input wire logic bclk_in,
    input wire logic bclk_out,
    input wire logic bclk_oe,
    input wire logic channel_select_clock_in,
    input wire logic channel_select_clock_out,
    input wire logic channel_select_clock_oe,
    input wire logic word_frame_out,
    input wire logic word_frame_oe,
    input wire logic serial_data_out
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic last_r, last_nxt;
    logic [3:0] run_r, run_nxt;
    logic [1:0] pin_r, pin_nxt;
    logic [5:0] hist_r, hist_nxt;
    always_comb begin
        last_nxt = bclk_out;
        run_nxt = (bclk_out != last_r) ? 4'h0 : run_r + {3'h0, run_r != 4'hf};
        pin_nxt = {bclk_in, channel_select_clock_in};
        // window spans the pin sync, edge detect and output register
        hist_nxt = {hist_r[4:0], pin_nxt != pin_r};
    end
    always_ff @(posedge mclk) begin
        last_r <= srst ? 1'h0 : last_nxt;
        run_r <= srst ? 4'h0 : run_nxt;
        pin_r <= srst ? 2'h0 : pin_nxt;
        hist_r <= srst ? 6'h00 : hist_nxt;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst || !reset_n);
    sequence s_launched;
        $past(bclk_out) != $past(bclk_out, 2);
    endsequence
    sequence s_release;
        !reset_n ##1 reset_n;
    endsequence
    a_wf_input_only: assert property (
        !word_frame_oe |-> !bclk_oe && !channel_select_clock_oe) else $error("frame pin released");
    a_data_launch: assert property (
        $rose(serial_data_out) && bclk_oe |-> s_launched) else $error("data off launch edge");
    a_chan_launch: assert property (
        $rose(channel_select_clock_out) && bclk_oe |-> s_launched) else $error("channel off edge");
    a_bclk_half: assert property (
        bclk_out && !last_r && bclk_oe |-> run_r >= DIV_HALF - 1) else $error("bit clock short");
    a_slave_cause: assert property (
        $rose(serial_data_out) && !bclk_oe |-> hist_r != 6'h00) else $error("slave data uncaused");
    a_srst_quiet: assert property (disable iff (!reset_n)
        srst |=> !serial_data_out && bclk_oe && word_frame_oe) else $error("sync reset state");
    a_async_quiet: assert property (disable iff (srst)
        !reset_n |-> !serial_data_out && !word_frame_out) else $error("async reset state");
    a_release_hold: assert property (disable iff (srst)
        s_release |-> !serial_data_out && !bclk_out) else $error("reset release early");
endmodule

bind adc_serial_output_port sop_checker #(.DIV_HALF(DIV_HALF)) i_chk (
    .mclk, .srst, .reset_n, .bclk_in, .bclk_out, .bclk_oe, .channel_select_clock_in,
    .channel_select_clock_out, .channel_select_clock_oe, .word_frame_out, .word_frame_oe,
    .serial_data_out
);

// >>> verification/sop_receiver.sv
`timescale 1ns/1ps
module sop_receiver (
    // bench control
    input wire logic run,
    input wire logic pol,
    input wire logic [4:0] pos_l,
    input wire logic [4:0] pos_r,
    // link pins
    output logic bclk,
    output logic chan,
    output logic wf
);
    // ----------------------------------------
    // frame source, all from one timebase
    // ----------------------------------------
    initial begin
        bclk = 1'h0;
        chan = 1'h0;
        wf = 1'h0;
        forever begin
            wait (run);
            // bit clock stands still between frames
            bclk = pol;
            for (int f = 0; f < 2; f++) begin
                #31 chan = ~chan;
                #31.5;
                for (int i = 0; i < 32; i++) begin
                    bclk = ~pol;
                    wf = (i == (f == 0 ? pos_l : pos_r));
                    #62.5 bclk = pol;
                    if (i < 31) #62.5;
                end
            end
            // let the bench drop run before another frame may start
            wait (!run);
        end
    end
endmodule

// >>> verification/adc_serial_output_port_tb_top.sv
`timescale 1ns/1ps
module adc_serial_output_port_tb_top import sop_pkg::*; ();
    `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
        $display("Error %0t: got %h want %h", $time, g, e); end end
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam logic [15:0] LW = 16'ha5c3;
    localparam logic [15:0] RW = 16'h8001;
    int bad_count = 0;
    int comparisons = 0;
    logic mclk = 1'h0;
    logic srst = 1'h1;
    logic reset_n = 1'h1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic bclk_out, bclk_oe, channel_select_clock_out, channel_select_clock_oe;
    logic word_frame_out, word_frame_oe, serial_data_out, p_bclk, p_chan, p_wf;
    logic run = 1'h0, pol = 1'h0;
    logic [4:0] pos_l = 5'h00, pos_r = 5'h00;
    // whoever holds the enable drives the shared wire
    wire bclk_in = bclk_oe ? bclk_out : p_bclk;
    wire channel_select_clock_in = channel_select_clock_oe ? channel_select_clock_out : p_chan;
    wire word_frame_in = word_frame_oe ? word_frame_out : p_wf;
    adc_serial_output_port #(.DIV_HALF(2)) i_dut (
        .mclk, .srst, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .bclk_in, .bclk_out, .bclk_oe, .channel_select_clock_in,
        .channel_select_clock_out, .channel_select_clock_oe, .word_frame_in, .word_frame_out,
        .word_frame_oe, .serial_data_out
    );
    sop_receiver i_rcv (.run, .pol, .pos_l, .pos_r, .bclk(p_bclk), .chan(p_chan), .wf(p_wf));
    initial begin
        forever #5 mclk = ~mclk;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_of_test();
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // handshakes are judged at the falling edge, acted on at the next rising one
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, tb;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge mclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            if (tb) `CHK(s_axi_bresp, r)
            @(posedge mclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            if (tb) s_axi_bready <= 1'h0;
        end while (!tb);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge mclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            if (tr) `CHK({s_axi_rresp, s_axi_rdata}, {er, ed})
            @(posedge mclk);
            if (ta) s_axi_arvalid <= 1'h0;
            if (tr) s_axi_rready <= 1'h0;
        end while (!tr);
    endtask
    task automatic set(input mode_t m);
        wr(CTRL_OFS, {27'h000_0000, m}, RESP_OKAY);
    endtask
    function automatic logic [63:0] frm(input logic [4:0] ml, input logic [4:0] mr);
        frm = ({LW, 48'h0000_0000_0000} >> ml) | ({RW, 48'h0000_0000_0000} >> (mr + 32));
    endfunction
    // one frame from the left field, sampled at the valid edge only
    task automatic cap(output logic [63:0] d, output logic [63:0] w, output logic [63:0] c);
        int n;
        n = 0;
        @(posedge channel_select_clock_in);
        while (n < 64) begin
            @(bclk_in);
            if (bclk_in === pol) begin
                d[63 - n] = serial_data_out;
                w[63 - n] = word_frame_in;
                c[63 - n] = channel_select_clock_in;
                n++;
            end
        end
    endtask
    task automatic t_master(input logic j, input logic dn, input logic p, input logic [4:0] m,
                            input logic [31:0] wp);
        logic [63:0] d, w, c, mk;
        // with the right-justified delayed msb the lsb of the old right word lands in left bit 0
        mk = (j && !dn) ? 64'h7fff_ffff_ffff_ffff : ~64'h0000_0000_0000_0000;
        pol = p;
        set(5'h00);
        set({1'h1, p, dn, j, 1'h0});
        `CHK(word_frame_oe, 1'h1)
        cap(d, w, c);
        `CHK(d & mk, frm(m, m) & mk)
        `CHK(w, {wp, wp})
        `CHK(c, {32'hffff_ffff, 32'h0000_0000})
    endtask
    task automatic t_slave(input mode_t m, input logic [4:0] ml, input logic [4:0] mr,
                           input logic [31:0] wp);
        logic [63:0] d, w, c;
        set(5'h00);
        pos_l = 5'h0f;
        pos_r = 5'h00;
        pol = m.polarity;
        set(m);
        `CHK({word_frame_oe, bclk_oe}, {~m.justify_select | m.msb_delay_select_n, 1'h0})
        run = 1'h1;
        cap(d, w, c);
        run = 1'h0;
        `CHK(d, frm(ml, mr))
        // the frame pin is only the device's own output outside the frame-input mode
        if (word_frame_oe) `CHK(w, {wp, wp})
    endtask
    task automatic t_reset();
        set({1'h1, 1'h0, 1'h1, 1'h0, 1'h0});
        repeat (40) @(posedge mclk);
        reset_n <= 1'h0;
        #2;
        `CHK({bclk_out, channel_select_clock_out, word_frame_out, serial_data_out}, 4'h0)
        repeat (4) @(posedge mclk);
        reset_n <= 1'h1;
        repeat (3) @(posedge mclk);
        rd(CTRL_OFS, {27'h000_0000, CTRL_RESET}, RESP_OKAY);
        rd(STATUS_OFS, {27'h000_0000, FIELD_LAST}, RESP_OKAY);
    endtask
    // ----------------------------------------
    // sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge mclk);
        srst <= 1'h0;
        rd(CTRL_OFS, {27'h000_0000, CTRL_RESET}, RESP_OKAY);
        rd(4'h6, 32'h0000_0000, RESP_SLVERR);
        wr(LEFT_OFS, {16'h0000, LW}, RESP_OKAY);
        wr(RIGHT_OFS, {16'h0000, RW}, RESP_OKAY);
        t_master(1'h0, 1'h1, 1'h0, POS_LEFT, 32'hffff_0000);
        t_master(1'h0, 1'h0, 1'h1, POS_I2S, 32'h7fff_8000);
        t_master(1'h1, 1'h1, 1'h0, POS_RIGHT, 32'h0000_ffff);
        t_master(1'h1, 1'h0, 1'h1, POS_RIGHT_DLY, 32'h0000_8000);
        t_slave({1'h1, 1'h1, 1'h0, 1'h1, 1'h1}, POS_RIGHT, POS_I2S, 32'h0000_0000);
        t_slave({1'h1, 1'h0, 1'h1, 1'h0, 1'h1}, POS_LEFT, POS_LEFT, 32'hffff_0000);
        t_reset();
        end_of_test();
    end
    initial begin
        #200_000;
        bad_count++;
        end_of_test();
    end
endmodule
